// [sim/rf_front_model.sv]
/* front-end model: turns a received level into the comparator output.
   assumes the code input comes from the sequencer's threshold port. */
`timescale 1ns/1ps
module rf_front_model (
  input  wire logic [2:0] code_i,  // selected threshold step
  input  wire logic [3:0] level_i, // received level, in steps
  output logic            above_o  // high while level above step
);
  // equal to the step counts as not above
  assign above_o = level_i > {1'b0, code_i};
endmodule : rf_front_model

// [sim/tb_rf_activity_power_sequencer.sv]
/* bench for the activity sequencer: bus tasks, front-end model, note queues.
   assumes short delay parameters; onset and warm-up as in the package. */
`timescale 1ns/1ps
module tb_rf_activity_power_sequencer;
  import rf_seq_pkg::*;
  localparam int F = 20;
  localparam int S = 30;
  localparam int T = 40;
  localparam int H = 600;
  typedef struct packed {logic [3:0] v; int d;} note_t;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        en = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        above;
  logic        f1, s1, s2, s3, wq;
  logic [2:0]  sel = 3'h0;
  logic [2:0]  code;
  logic [3:0]  lvl = 4'h0;
  logic [3:0]  be = 4'hF;
  logic [3:0]  vec;
  logic [3:0]  last_vec = 4'h0;
  logic [1:0]  adr = 2'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [7:0]  seed = 8'h2A;
  note_t       vq[$];
  logic [31:0] rq[$];
  note_t       n;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          last_cyc = 0;

  always #10 ref_clk_i = ~ref_clk_i;
  assign vec = {f1, s3, s2, s1};

  rf_front_model u_front (.code_i(code), .level_i(lvl), .above_o(above));
  rf_activity_power_sequencer #(.FIRST_DLY(CNT_W'(F)), .SECOND_DLY(CNT_W'(S)),
    .THIRD_DLY(CNT_W'(T)), .HOLD_DLY(CNT_W'(H))) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .level_above_i(above), .enable_i(en),
    .threshold_sel_msb_i(sel[2]), .threshold_sel_mid_i(sel[1]),
    .threshold_sel_lsb_i(sel[0]), .threshold_code_o(code), .signal_active_flag_o(f1),
    .seq_out_first_o(s1), .seq_out_second_o(s2), .seq_out_third_o(s3),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // output watcher: each change of the outputs takes the oldest note
  always @(negedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (!rst_i && vec !== last_vec) begin
      if (vq.size() == 0) check({28'h0, vec}, 32'hFF);
      else begin
        n = vq.pop_front();
        check({28'h0, vec}, {28'h0, n.v});
        if (n.d != 0) check(32'(cyc - last_cyc), 32'(n.d));
      end
      last_vec <= vec;
      last_cyc <= cyc;
    end
    if (rd && !wq) check(rdat, rq.pop_front());
  end

  task automatic cycles(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask : cycles

  task automatic push(input logic [3:0] v, input int d);
    vq.push_back('{v, d});
  endtask : push

  task automatic timeout_if(input logic hit);
    if (hit) begin
      check(32'h0, 32'h1);
      final_report;
    end
  endtask : timeout_if

  task automatic wait_vec(input logic [3:0] v, input int lim);
    int i;
    i = 0;
    while (vec !== v && i < lim) begin
      @(negedge ref_clk_i);
      i++;
    end
    timeout_if(i >= lim);
    @(posedge ref_clk_i);
  endtask : wait_vec

  // one avalon access; for a read d is the expected data
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int i;
    if (!w) rq.push_back(d);
    @(posedge ref_clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    i = 0;
    @(posedge ref_clk_i);
    while (wq !== 1'b0 && i < 20) begin
      @(posedge ref_clk_i);
      i++;
    end
    timeout_if(i >= 20);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rf(input logic up);
    @(posedge ref_clk_i);
    lvl <= up ? 4'(sel) + 4'h1 + {2'h0, seed[4:3]} : {1'b0, sel};
  endtask : rf

  task automatic pick;
    seed = lfsr(seed);
    @(posedge ref_clk_i);
    lvl <= 4'h0;
    sel <= seed[2:0];
    cycles(6);
  endtask : pick

  task automatic push_seq;
    push(4'h8, 0);
    push(4'h9, F);
    push(4'hB, S);
    push(4'hF, T);
  endtask : push_seq

  initial begin
    cycles(5);
    rst_i <= 1'b0;
    cycles(1700);
    bus(0, ADDR_CTRL, CTRL_RESET, 4'hF);
    for (int c = 0; c < 8; c++) begin
      @(posedge ref_clk_i);
      sel <= 3'(c);
      cycles(6);
      check({29'h0, code}, 32'(c));
      bus(0, ADDR_STATUS, (32'(c) << STAT_THR_LSB) | (32'h1 << STAT_RUN_BIT),
          4'hF);
    end
    $display("threshold test done");
    pick();
    push_seq();
    rf(1);
    wait_vec(4'hF, 1000);
    bus(0, ADDR_STATUS, (32'h1 << STAT_FLAG_BIT) | (32'h7 << STAT_SEQ_LSB)
        | (32'h1 << STAT_RUN_BIT) | (32'(sel) << STAT_THR_LSB), 4'hF);
    push(4'h7, 0);
    rf(0);
    wait_vec(4'h7, 20);
    cycles(50);
    push(4'hF, 0);
    rf(1);
    wait_vec(4'hF, 400);
    push(4'h7, 0);
    push(4'h0, H);
    rf(0);
    wait_vec(4'h0, 700);
    $display("sequence test done");
    pick();
    push(4'h8, 0);
    push(4'h9, F);
    rf(1);
    wait_vec(4'h9, 500);
    push(4'h1, 0);
    push(4'h0, H);
    rf(0);
    wait_vec(4'h0, 700);
    $display("early loss test done");
    pick();
    push_seq();
    rf(1);
    wait_vec(4'hF, 1000);
    push(4'h0, 0);
    en <= 1'b0;
    wait_vec(4'h0, 10);
    cycles(20);
    push(4'h8, 0);
    push(4'h9, F);
    en <= 1'b1;
    wait_vec(4'h9, 5000 + 300 + F);
    push(4'h0, 0);
    bus(1, ADDR_CTRL, 32'h1, 4'hF);
    wait_vec(4'h0, 10);
    bus(0, ADDR_CTRL, 32'h1, 4'hF);
    bus(1, ADDR_CTRL, 32'h0, 4'hE);
    bus(0, ADDR_CTRL, 32'h1, 4'hF);
    bus(1, 2'h2, 32'hFFFF_FFFF, 4'hF);
    bus(0, 2'h3, 32'h0, 4'hF);
    rf(0);
    bus(1, ADDR_CTRL, 32'h0, 4'hF);
    bus(0, ADDR_CTRL, 32'h0, 4'hF);
    $display("power-down test done");
    final_report();
  end
endmodule : tb_rf_activity_power_sequencer

// [src/rf_activity_power_sequencer.sv]
/*
 * activity flag, timed three-output power-on sequence and common hold-off,
 * with an avalon-mm slave for a park control bit and a status word.
 * assumes the level input comes from an analog comparator (asynchronous),
 * enable and threshold select from pins; all are synchronised here.
 */
`timescale 1ns/1ps
module rf_activity_power_sequencer
  import rf_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] FIRST_DLY  = CNT_W'(FIRST_CYC),
  parameter logic [CNT_W-1:0] SECOND_DLY = CNT_W'(SECOND_CYC),
  parameter logic [CNT_W-1:0] THIRD_DLY  = CNT_W'(THIRD_CYC),
  parameter logic [CNT_W-1:0] HOLD_DLY   = CNT_W'(HOLD_CYC)
) (
  input  wire logic        ref_clk_i,            // system clock, 50 MHz
  input  wire logic        rst_i,                // async reset, active high
  input  wire logic        level_above_i,        // comparator: level above threshold
  input  wire logic        enable_i,             // pin, low = power-down
  input  wire logic        threshold_sel_msb_i,  // threshold select bit 2
  input  wire logic        threshold_sel_mid_i,  // threshold select bit 1
  input  wire logic        threshold_sel_lsb_i,  // threshold select bit 0
  output logic [2:0]       threshold_code_o,     // step code to comparator
  output logic             signal_active_flag_o, // activity flag
  output logic             seq_out_first_o,      // first sequencer output
  output logic             seq_out_second_o,     // second sequencer output
  output logic             seq_out_third_o,      // third sequencer output
  input  wire logic [1:0]  avs_address_i,        // word address
  input  wire logic        avs_read_i,           // read strobe
  input  wire logic        avs_write_i,          // write strobe
  input  wire logic [3:0]  avs_byteenable_i,     // byte enables
  input  wire logic [31:0] avs_writedata_i,      // write data
  output logic [31:0]      avs_readdata_o,       // read data
  output logic             avs_waitrequest_o     // stall while ack not yet
);

  typedef struct packed {
    logic             above_m;
    logic             above_s;
    logic             en_m;
    logic             en_s;
    logic [2:0]       thr_m;
    logic [2:0]       thr_s;
    phase_t           phase;
    logic [CNT_W-1:0] warm_cnt;
    logic [CNT_W-1:0] onset_cnt;
    logic             flag;
    logic [2:0]       seq_on;
    logic             ctrl_park;
    logic             ack;
    logic [31:0]      rdata;
    // helper counts for the checks only; they steer nothing
    logic [2:0]       on_q;
    logic [CNT_W-1:0] flag_cycles;
    logic [CNT_W-1:0] low_cycles;
    logic [CNT_W-1:0] step_cycles;
  } seq_state_t;

  seq_state_t st;
  seq_state_t next_st;

  logic             running;
  logic             go;
  logic             seq_run;
  logic             seq_done;
  logic             hold_run;
  logic             hold_done;
  logic [CNT_W-1:0] seq_limit;

  assign running  = (st.phase == PH_RUN);
  assign go       = st.en_s && !st.ctrl_park;
  assign seq_run  = running && st.flag && !st.seq_on[2];
  assign hold_run = running && !st.flag && (st.seq_on != 3'h0);

  always_comb begin
    if (!st.seq_on[0]) begin
      seq_limit = FIRST_DLY;
    end else if (!st.seq_on[1]) begin
      seq_limit = SECOND_DLY;
    end else begin
      seq_limit = THIRD_DLY;
    end
  end

  seq_timer #(
    .W (CNT_W)
  ) u_seq_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .run_i     (seq_run),
    .limit_i   (seq_limit),
    .done_o    (seq_done)
  );

  seq_timer #(
    .W (CNT_W)
  ) u_hold_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .run_i     (hold_run),
    .limit_i   (HOLD_DLY),
    .done_o    (hold_done)
  );

  always_comb begin
    next_st = st;
    next_st.above_m = level_above_i;
    next_st.above_s = st.above_m;
    next_st.en_m    = enable_i;
    next_st.en_s    = st.en_m;
    next_st.thr_m   = {threshold_sel_msb_i, threshold_sel_mid_i, threshold_sel_lsb_i};
    next_st.thr_s   = st.thr_m;

    case (st.phase)
      PH_DOWN: begin
        if (go) begin
          next_st.phase    = PH_WARM;
          next_st.warm_cnt = '0;
        end
      end
      PH_WARM: begin
        if (st.warm_cnt == WARM_LAST) begin
          next_st.phase = PH_RUN;
        end else begin
          next_st.warm_cnt = st.warm_cnt + CNT_W'(1);
        end
      end
      PH_RUN: begin
        if (!st.above_s) begin
          next_st.flag      = 1'b0;
          next_st.onset_cnt = '0;
        end else if (!st.flag) begin
          if (st.onset_cnt == ONSET_LAST) begin
            next_st.flag = 1'b1;
          end else begin
            next_st.onset_cnt = st.onset_cnt + CNT_W'(1);
          end
        end
        if (seq_done) begin
          if (!st.seq_on[0]) begin
            next_st.seq_on[0] = 1'b1;
          end else if (!st.seq_on[1]) begin
            next_st.seq_on[1] = 1'b1;
          end else begin
            next_st.seq_on[2] = 1'b1;
          end
        end
        if (hold_done) begin
          next_st.seq_on = 3'h0;
        end
      end
      default: begin
        next_st.phase = PH_DOWN;
      end
    endcase

    if (!go) begin
      next_st.phase     = PH_DOWN;
      next_st.warm_cnt  = '0;
      next_st.onset_cnt = '0;
      next_st.flag      = 1'b0;
      next_st.seq_on    = 3'h0;
    end

    // bus slave: one wait cycle, write lands on the released edge
    if (st.ack) begin
      next_st.ack = 1'b0;
      if (avs_write_i && avs_address_i == ADDR_CTRL && avs_byteenable_i[0]) begin
        next_st.ctrl_park = avs_writedata_i[CTRL_PARK_BIT];
      end
    end else if (avs_read_i || avs_write_i) begin
      next_st.ack   = 1'b1;
      next_st.rdata = 32'h0000_0000;
      if (avs_read_i) begin
        case (avs_address_i)
          ADDR_CTRL: begin
            next_st.rdata[CTRL_PARK_BIT] = st.ctrl_park;
          end
          ADDR_STATUS: begin
            next_st.rdata[STAT_FLAG_BIT]                  = st.flag;
            next_st.rdata[STAT_SEQ_LSB +: 3]              = st.seq_on;
            next_st.rdata[STAT_RUN_BIT]                   = running;
            next_st.rdata[STAT_THR_LSB +: 3]              = st.thr_s;
          end
          default: begin
            next_st.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // cycles since flag rise, since hold-off start, since the last output rise
    next_st.on_q        = st.seq_on;
    next_st.flag_cycles = st.flag ? st.flag_cycles + CNT_W'(1) : '0;
    next_st.low_cycles  = hold_run ? st.low_cycles + CNT_W'(1) : '0;
    if ((st.seq_on & ~st.on_q) != 3'h0) begin
      next_st.step_cycles = CNT_W'(1);
    end else if (st.flag) begin
      next_st.step_cycles = st.step_cycles + CNT_W'(1);
    end else begin
      next_st.step_cycles = '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign threshold_code_o     = st.thr_s;
  assign signal_active_flag_o = st.flag;
  assign seq_out_first_o      = st.seq_on[0];
  assign seq_out_second_o     = st.seq_on[1];
  assign seq_out_third_o      = st.seq_on[2];
  assign avs_readdata_o       = st.rdata;
  assign avs_waitrequest_o    = (avs_read_i || avs_write_i) && !st.ack;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_flag_needs_level: assert property (
    st.flag |-> running && $past(st.above_s)
  ) else $error("activity flag high without level above threshold");

  a_flag_drop_fast: assert property (
    st.flag && !st.above_s |=> !st.flag
  ) else $error("activity flag did not drop one cycle after level loss");

  a_onset_delay: assert property (
    $rose(st.flag) |-> $past(st.onset_cnt) == ONSET_LAST && $past(go)
  ) else $error("activity flag rose before the onset delay");

  a_first_delay: assert property (
    $rose(st.seq_on[0]) |-> st.flag_cycles == FIRST_DLY
  ) else $error("first output delay wrong");

  a_output_order: assert property (
    (st.seq_on[1] |-> st.seq_on[0]) and (st.seq_on[2] |-> st.seq_on[1])
  ) else $error("sequencer outputs out of order");

  a_rise_needs_flag: assert property (
    $rose(st.seq_on[0]) || $rose(st.seq_on[1]) || $rose(st.seq_on[2]) |-> $past(st.flag)
  ) else $error("output rose without activity");

  a_hold_while_active: assert property (
    go && st.flag && st.seq_on[0] |=> st.seq_on[0]
  ) else $error("output dropped while activity present");

  a_drop_together: assert property (
    $fell(st.seq_on[0]) |-> st.seq_on == 3'h0 && $past(st.seq_on) == 3'h7
                            || $past(st.seq_on[2]) == 1'b0 && st.seq_on == 3'h0
  ) else $error("outputs not released together");

  a_hold_length: assert property (
    $fell(st.seq_on[0]) && running |-> st.low_cycles == HOLD_DLY
  ) else $error("hold-off length wrong");

  a_down_clears: assert property (
    !go |=> !st.flag && st.seq_on == 3'h0 && !running
  ) else $error("power-down did not clear outputs");

  a_warm_time: assert property (
    $rose(running) |-> $past(st.warm_cnt) == WARM_LAST
  ) else $error("activation time wrong");

  a_second_delay: assert property (
    $rose(st.seq_on[1]) |-> st.step_cycles == SECOND_DLY
  ) else $error("second output delay wrong");

  a_third_delay: assert property (
    $rose(st.seq_on[2]) |-> st.step_cycles == THIRD_DLY
  ) else $error("third output delay wrong");

  a_hold_keeps: assert property (
    go && hold_run && st.low_cycles < HOLD_DLY - CNT_W'(1) |=> $stable(st.seq_on)
  ) else $error("outputs changed before the hold-off ended");

  a_hold_bound: assert property (
    hold_run |-> st.low_cycles < HOLD_DLY
  ) else $error("hold-off ran past its length");

  a_drop_cause: assert property (
    $fell(st.seq_on[0]) |-> $past(hold_run) || !$past(go)
  ) else $error("outputs dropped outside hold-off end or power-down");

  a_flag_rise_level: assert property (
    $rose(st.flag) |-> $past(st.above_s) && $past(running)
  ) else $error("activity flag rose without level or outside run");

  a_onset_wait: assert property (
    running && st.above_s && !st.flag && st.onset_cnt != ONSET_LAST |=> !st.flag
  ) else $error("activity flag rose before onset count completed");

  a_thr_code: assert property (
    threshold_code_o == $past(st.thr_m)
  ) else $error("threshold code does not follow the select pins");

  a_park_down: assert property (
    st.ctrl_park |=> !running
  ) else $error("park bit did not stop the sequencer");

  a_pins_down: assert property (
    !st.en_s |=> !signal_active_flag_o && !seq_out_first_o
                 && !seq_out_second_o && !seq_out_third_o
  ) else $error("outputs active while enable low");

  a_warm_bound: assert property (
    st.phase == PH_WARM |-> st.warm_cnt <= WARM_LAST
  ) else $error("warm-up counter overran");

  a_timers_clear: assert property (
    !go |=> st.warm_cnt == '0 && st.onset_cnt == '0
  ) else $error("timers not cleared in power-down");

  a_idle_quiet: assert property (
    !running |-> !st.flag && st.seq_on == 3'h0
  ) else $error("flag or outputs active outside run");

  a_low_no_rise: assert property (
    !st.flag |=> st.seq_on == $past(st.seq_on) || st.seq_on == 3'h0
  ) else $error("output rose while activity absent");

endmodule : rf_activity_power_sequencer

// [src/rf_seq_pkg.sv]
/*
 * constants, timing figures and types shared by the activity power sequencer.
 * assumes a single system clock at CLK_HZ; all times become cycle counts here.
 */
package rf_seq_pkg;

  localparam longint CLK_HZ        = 50_000_000;
  localparam int     CNT_W         = 32;

  // times in their own units, as specified
  localparam longint ONSET_US      = 6;
  localparam longint WARM_US       = 33;
  localparam longint FIRST_MS      = 5;
  localparam longint SECOND_MS     = 10;
  localparam longint THIRD_MS      = 35;
  localparam longint HOLD_S        = 30;

  // cycle counts, rounded up to whole cycles
  localparam longint ONSET_CYC     = (ONSET_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint WARM_CYC      = (WARM_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint FIRST_CYC     = (FIRST_MS * CLK_HZ + 999) / 1_000;
  localparam longint SECOND_CYC    = (SECOND_MS * CLK_HZ + 999) / 1_000;
  localparam longint THIRD_CYC     = (THIRD_MS * CLK_HZ + 999) / 1_000;
  localparam longint HOLD_CYC      = HOLD_S * CLK_HZ;

  localparam logic [CNT_W-1:0] ONSET_LAST = CNT_W'(ONSET_CYC - 1);
  localparam logic [CNT_W-1:0] WARM_LAST  = CNT_W'(WARM_CYC - 1);

  // register word addresses
  localparam logic [1:0] ADDR_CTRL     = 2'h0;
  localparam logic [1:0] ADDR_STATUS   = 2'h1;

  // field positions
  localparam int CTRL_PARK_BIT         = 0;
  localparam int STAT_FLAG_BIT         = 0;
  localparam int STAT_SEQ_LSB          = 1;
  localparam int STAT_RUN_BIT          = 4;
  localparam int STAT_THR_LSB          = 5;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

  typedef enum logic [1:0] {PH_DOWN, PH_WARM, PH_RUN} phase_t;

endpackage : rf_seq_pkg

// [src/seq_timer.sv]
/*
 * interval timer: counts cycles while run is high, pulses done on the
 * cycle that completes limit cycles, then restarts from zero.
 * assumes run and limit come from logic on the same clock.
 */
`timescale 1ns/1ps
module seq_timer
  import rf_seq_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         ref_clk_i, // system clock
  input  wire logic         rst_i,     // async reset, active high
  input  wire logic         run_i,     // count while high, clear while low
  input  wire logic [W-1:0] limit_i,   // interval length in cycles
  output logic              done_o     // one-cycle pulse at interval end
);

  typedef struct packed {
    logic [W-1:0] count;
  } tmr_state_t;

  tmr_state_t st;
  tmr_state_t next_st;

  assign done_o = run_i && (st.count == limit_i - W'(1));

  always_comb begin
    next_st = st;
    if (!run_i || done_o) begin
      next_st.count = '0;
    end else begin
      next_st.count = st.count + W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : seq_timer
